//--- logic/bem_monitor.sv
// Bus efficiency monitor and protocol checker with register port
// Contract
// - Count transfer cycles and wait cycles separately
// - Statistics readable over own register port
// - Check every master command for legality
// - Illegal command sets readable status flag
// - Track smallest and largest read latency
// - Push timestamp per accepted read command
// - First data beat pops stamp, computes latency
// - Bit 16 runs; zero bits 0,8 reset
// - Minimum at 0x40, maximum at 0x44
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`include "bem_cfg.svh"
module bem_monitor #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 64,
    parameter int BE_W = 8,
    parameter int BURST_W = 8,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic [ADDR_W-1:0] MON_ADDRESS_I,
    input wire logic MON_READ_I,
    input wire logic MON_WRITE_I,
    input wire logic [BURST_W-1:0] MON_BURSTCOUNT_I,
    input wire logic MON_WAITREQUEST_I,
    input wire logic MON_READDATAVALID_I,
    output logic IRQ_O
);
    localparam int FW = 32 + BURST_W;
    localparam int NC = `BEM_NUM_CNT;
    logic wait_reg; // Register port waitrequest
    logic [31:0] rdata_reg; // Register port read data
    logic [31:0] rd_mux; // Selected read word
    logic wr_go; // Register write takes effect
    logic rd_go; // Register read completes
    logic run_reg; // Gathering enabled
    bem_pkg::bem_state_t state_reg; // Gathering state
    logic stat_clr; // Statistic reset pulse
    logic chk_clr; // Checker and latency reset pulse
    logic [31:0] time_reg; // Free-running time
    logic [31:0] cnt_reg [NC]; // Live counters
    logic [31:0] snap_reg [NC]; // Snapshot copies
    logic [31:0] amt [NC]; // Per-counter increment
    logic [NC-1:0] sat_hit; // Counter at its limit
    logic sat_reg; // Some counter saturated
    logic cmd; // Master presents a command
    logic rd_acc; // Read command accepted
    logic wr_acc; // Write command accepted
    logic [BURST_W-1:0] wr_left_reg; // Write beats still due
    logic [BURST_W-1:0] rd_left_reg; // Read beats still due
    logic pending; // Read data outstanding
    logic first_beat; // First beat of a read burst
    logic [31:0] latency; // Latency of this read
    logic [31:0] lat_min_reg; // Smallest latency
    logic [31:0] lat_max_reg; // Largest latency
    logic [`BEM_CHK_W-1:0] chk_reg; // Checker flags
    logic [`BEM_CHK_W-1:0] chk_hit; // Violations this cycle
    logic prev_cmd_reg; // Command stalled last cycle
    logic [ADDR_W-1:0] prev_addr_reg; // Held address
    logic prev_rd_reg; // Held read
    logic [BURST_W-1:0] prev_burst_reg; // Held burst count
    logic ovf_hit; // Read lost for a full queue
    logic [`BEM_IRQ_W-1:0] irq_stat_reg; // Sticky events
    logic [`BEM_IRQ_W-1:0] irq_en_reg; // Event enables
    logic [`BEM_IRQ_W-1:0] irq_set; // Events this cycle
    logic irq_pend; // Enabled event present
    logic irq_reg; // Interrupt output

    bem_fifo_if #(.W(FW)) fi ();

    // Timestamp queue
    bem_stamp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(CLOCK_I),
        .rst_n_i(RSTN_I && !chk_clr),
        .f(fi)
    );

    // Register port: answer one cycle after the request
    assign wr_go = AVS_WRITE_I && !wait_reg;
    assign rd_go = AVS_READ_I && !wait_reg;
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end
        else if ((AVS_READ_I || AVS_WRITE_I) && wait_reg)
        begin
            wait_reg <= 1'b0;
            rdata_reg <= AVS_READ_I ? rd_mux : 32'h0;
        end
        else
        begin
            wait_reg <= 1'b1;
        end
    end
    assign AVS_WAITREQUEST_O = wait_reg;
    assign AVS_READDATA_O = rdata_reg;

    // Read word selection; unmapped words read zero
    always_comb
    begin
        rd_mux = 32'h0;
        case (AVS_ADDRESS_I)
            `BEM_IDX_ID: rd_mux = 32'h0;
            `BEM_IDX_VER: rd_mux = `BEM_VERSION;
            `BEM_IDX_CTRL:
            begin
                rd_mux[`BEM_CTRL_RUN] = run_reg;
                rd_mux[`BEM_CTRL_ST_LSB] = state_reg == bem_pkg::BEM_STOPPED;
                rd_mux[`BEM_CTRL_ST_LSB + 1] =
                    state_reg == bem_pkg::BEM_WAITING;
                rd_mux[`BEM_CTRL_ST_LSB + 2] =
                    state_reg == bem_pkg::BEM_RUNNING;
                rd_mux[`BEM_CTRL_ST_LSB + 3] = sat_reg;
            end
            `BEM_IDX_WIDTHS: rd_mux = {16'(DATA_W), 16'(ADDR_W)};
            `BEM_IDX_BWIDTHS: rd_mux = {16'(BURST_W), 16'(BE_W)};
            `BEM_IDX_LAT_MIN: rd_mux = lat_min_reg;
            `BEM_IDX_LAT_MAX: rd_mux = lat_max_reg;
            `BEM_IDX_CHECK: rd_mux = 32'(chk_reg);
            `BEM_IDX_IRQ_STAT: rd_mux = 32'(irq_stat_reg);
            `BEM_IDX_IRQ_EN: rd_mux = 32'(irq_en_reg);
            default:
            begin
                // Snapshot counters at 0x14 onward, four indices apart
                for (int k = 0; k < NC; k++)
                begin
                    if (AVS_ADDRESS_I == 8'(`BEM_IDX_CNT0
                        + k * `BEM_CNT_STRIDE))
                    begin
                        rd_mux = snap_reg[k];
                    end
                end
            end
        endcase
    end

    // Control word strobes; a zero written resets that logic
    assign stat_clr = wr_go && AVS_ADDRESS_I == `BEM_IDX_CTRL
        && AVS_BYTEENABLE_I[0]
        && !AVS_WRITEDATA_I[`BEM_CTRL_STAT_RST];
    assign chk_clr = wr_go && AVS_ADDRESS_I == `BEM_IDX_CTRL
        && AVS_BYTEENABLE_I[1]
        && !AVS_WRITEDATA_I[`BEM_CTRL_CHK_RST];

    // Start and stop of gathering
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            run_reg <= 1'b0;
        end
        else if (wr_go && AVS_ADDRESS_I == `BEM_IDX_CTRL
                 && AVS_BYTEENABLE_I[2])
        begin
            run_reg <= AVS_WRITEDATA_I[`BEM_CTRL_RUN];
        end
    end

    // Gathering state: waits for the first command once started
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            state_reg <= bem_pkg::BEM_STOPPED;
        end
        else
        begin
            case (state_reg)
                bem_pkg::BEM_STOPPED:
                    if (run_reg)
                    begin
                        state_reg <= bem_pkg::BEM_WAITING;
                    end
                bem_pkg::BEM_WAITING:
                    if (!run_reg)
                    begin
                        state_reg <= bem_pkg::BEM_STOPPED;
                    end
                    else if (cmd)
                    begin
                        state_reg <= bem_pkg::BEM_RUNNING;
                    end
                bem_pkg::BEM_RUNNING:
                    if (!run_reg)
                    begin
                        state_reg <= bem_pkg::BEM_STOPPED;
                    end
                default: state_reg <= bem_pkg::BEM_STOPPED;
            endcase
        end
    end

    // Free-running time base
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            time_reg <= 32'h0;
        end
        else
        begin
            time_reg <= time_reg + 32'h1;
        end
    end

    // Bus events seen on the controller input
    assign cmd = MON_READ_I || MON_WRITE_I;
    assign rd_acc = MON_READ_I && !MON_WAITREQUEST_I;
    assign wr_acc = MON_WRITE_I && !MON_WAITREQUEST_I;
    assign pending = !fi.empty || (rd_left_reg != '0);
    assign first_beat = MON_READDATAVALID_I && (rd_left_reg == '0);

    // Counter increments: transfers apart from each kind of wait
    always_comb
    begin
        amt[0] = 32'h1;
        amt[1] = 32'(wr_acc || MON_READDATAVALID_I);
        amt[2] = 32'(wr_acc);
        amt[3] = 32'(rd_acc);
        amt[4] = rd_acc ? 32'(MON_BURSTCOUNT_I) : 32'h0;
        amt[5] = 32'(cmd && MON_WAITREQUEST_I);
        amt[6] = 32'(!cmd && !MON_READDATAVALID_I && pending);
        amt[7] = 32'(!cmd && !MON_READDATAVALID_I && !pending
                     && wr_left_reg != '0);
        amt[8] = 32'(!cmd && !MON_READDATAVALID_I && !pending
                     && wr_left_reg == '0);
    end

    // Saturating statistic counters with snapshot copies
    genvar g;
    generate
        for (g = 0; g < NC; g++)
        begin : g_cnt
            logic [32:0] sum;
            assign sum = {1'b0, cnt_reg[g]} + {1'b0, amt[g]};
            assign sat_hit[g] = state_reg == bem_pkg::BEM_RUNNING
                && sum[32];
            always_ff @(posedge CLOCK_I)
            begin
                if (!RSTN_I || stat_clr)
                begin
                    cnt_reg[g] <= 32'h0;
                end
                else if (state_reg == bem_pkg::BEM_RUNNING)
                begin
                    // Hold at the limit instead of wrapping
                    cnt_reg[g] <= sum[32] ? `BEM_CNT_MAX
                                  : sum[31:0];
                end
            end
            always_ff @(posedge CLOCK_I)
            begin
                if (!RSTN_I)
                begin
                    snap_reg[g] <= 32'h0;
                end
                else if (rd_go && AVS_ADDRESS_I == `BEM_IDX_ID)
                begin
                    snap_reg[g] <= cnt_reg[g];
                end
            end
        end
    endgenerate

    // Saturation indication, kept until statistics reset
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            sat_reg <= 1'b0;
        end
        else if (|sat_hit)
        begin
            sat_reg <= 1'b1;
        end
        else if (stat_clr)
        begin
            sat_reg <= 1'b0;
        end
    end

    // Write burst beat tracking
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I || chk_clr)
        begin
            wr_left_reg <= '0;
        end
        else if (wr_acc)
        begin
            wr_left_reg <= (wr_left_reg == '0)
                ? MON_BURSTCOUNT_I - 1'b1 : wr_left_reg - 1'b1;
        end
    end

    // Stamp each accepted read; pop at the first returned beat
    assign fi.push = rd_acc;
    assign fi.wdata = {MON_BURSTCOUNT_I, time_reg};
    assign fi.pop = first_beat;
    assign latency = time_reg - fi.rdata[31:0];
    assign ovf_hit = rd_acc && fi.full && !first_beat;

    // Read burst beat tracking
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I || chk_clr)
        begin
            rd_left_reg <= '0;
        end
        else if (MON_READDATAVALID_I && !(first_beat && fi.empty))
        begin
            // A stray beat finds no queued burst and is ignored
            rd_left_reg <= first_beat
                ? fi.rdata[FW-1:32] - 1'b1 : rd_left_reg - 1'b1;
        end
    end

    // Minimum and maximum read latency while gathering
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I || chk_clr)
        begin
            lat_min_reg <= `BEM_LAT_MIN_RST;
            lat_max_reg <= 32'h0;
        end
        else if (first_beat && !fi.empty
                 && state_reg == bem_pkg::BEM_RUNNING)
        begin
            if (latency < lat_min_reg)
            begin
                lat_min_reg <= latency;
            end
            if (latency > lat_max_reg)
            begin
                lat_max_reg <= latency;
            end
        end
    end

    // Legality checks on the master command
    always_comb
    begin
        chk_hit = '0;
        chk_hit[`BEM_CHK_BOTH] = MON_READ_I && MON_WRITE_I;
        chk_hit[`BEM_CHK_ZBURST] = cmd
            && MON_BURSTCOUNT_I == '0;
        chk_hit[`BEM_CHK_UNSTABLE] = prev_cmd_reg
            && (!cmd || MON_READ_I != prev_rd_reg
                || MON_ADDRESS_I != prev_addr_reg
                || MON_BURSTCOUNT_I != prev_burst_reg);
        chk_hit[`BEM_CHK_STRAY] = MON_READDATAVALID_I
            && !pending;
    end

    // Command held under waitrequest, for the stability check
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I || chk_clr)
        begin
            prev_cmd_reg <= 1'b0;
            prev_rd_reg <= 1'b0;
            prev_addr_reg <= '0;
            prev_burst_reg <= '0;
        end
        else
        begin
            prev_cmd_reg <= cmd && MON_WAITREQUEST_I;
            prev_rd_reg <= MON_READ_I;
            prev_addr_reg <= MON_ADDRESS_I;
            prev_burst_reg <= MON_BURSTCOUNT_I;
        end
    end

    // Sticky checker flags; a new violation beats the reset
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            chk_reg <= '0;
        end
        else
        begin
            chk_reg <= (chk_clr ? '0 : chk_reg) | chk_hit;
        end
    end

    // Interrupt status, write-one clear and enables; set wins
    assign irq_set = {ovf_hit, |sat_hit, |chk_hit};
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            irq_stat_reg <= '0;
            irq_en_reg <= '0;
        end
        else
        begin
            if (wr_go && AVS_ADDRESS_I == `BEM_IDX_IRQ_CLR
                && AVS_BYTEENABLE_I[0])
            begin
                irq_stat_reg <= (irq_stat_reg
                    & ~AVS_WRITEDATA_I[`BEM_IRQ_W-1:0]) | irq_set;
            end
            else
            begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
            if (wr_go && AVS_ADDRESS_I == `BEM_IDX_IRQ_EN
                && AVS_BYTEENABLE_I[0])
            begin
                irq_en_reg <= AVS_WRITEDATA_I[`BEM_IRQ_W-1:0];
            end
        end
    end

    // Level interrupt from a flip-flop
    assign irq_pend = |(irq_stat_reg & irq_en_reg);
    always_ff @(posedge CLOCK_I)
    begin
        if (!RSTN_I)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_pend;
        end
    end
    assign IRQ_O = irq_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    logic [31:0] cyc_cnt; // Cycle counter view
    logic [31:0] xfer_snap; // Transfer snapshot view
    assign cyc_cnt = cnt_reg[0];
    assign xfer_snap = snap_reg[1];

    port_answer_a: assert property (
        (AVS_READ_I || AVS_WRITE_I) && wait_reg
        |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
        else $error("register port answer not one cycle late");
    both_flag_a: assert property (
        MON_READ_I && MON_WRITE_I |=> chk_reg[`BEM_CHK_BOTH])
        else $error("read with write not flagged");
    cycle_count_a: assert property (
        state_reg == bem_pkg::BEM_RUNNING && !stat_clr
        && cyc_cnt != `BEM_CNT_MAX |=> cyc_cnt == $past(cyc_cnt) + 32'h1)
        else $error("cycle counter did not advance");
    stopped_hold_a: assert property (
        state_reg == bem_pkg::BEM_STOPPED && !stat_clr
        |=> $stable(cyc_cnt))
        else $error("counter moved while stopped");
    saturate_hold_a: assert property (
        state_reg == bem_pkg::BEM_RUNNING && !stat_clr
        && cyc_cnt == `BEM_CNT_MAX |=> cyc_cnt == `BEM_CNT_MAX && sat_reg)
        else $error("counter wrapped at its limit");
    stamp_push_a: assert property (
        rd_acc && fi.empty && !chk_clr
        |=> !fi.empty && fi.rdata[31:0] == $past(time_reg))
        else $error("accepted read not stamped");
    lat_order_a: assert property (
        lat_max_reg != 32'h0 |-> lat_min_reg <= lat_max_reg)
        else $error("latency minimum above maximum");
    lat_capture_a: assert property (
        first_beat && !fi.empty && !chk_clr
        && state_reg == bem_pkg::BEM_RUNNING
        |=> lat_max_reg >= $past(latency) && lat_min_reg <= $past(latency))
        else $error("read latency not captured");
    snap_take_a: assert property (
        rd_go && AVS_ADDRESS_I == `BEM_IDX_ID
        |=> xfer_snap == $past(cnt_reg[1]))
        else $error("snapshot not taken");
    irq_level_a: assert property (
        irq_pend |=> IRQ_O)
        else $error("interrupt not raised");

    run_seen_c: cover property (state_reg == bem_pkg::BEM_WAITING
        ##[1:20] state_reg == bem_pkg::BEM_RUNNING);
    lat_seen_c: cover property (rd_acc ##[1:50] first_beat);
    illegal_seen_c: cover property (|chk_hit);
    snap_seen_c: cover property (rd_go && AVS_ADDRESS_I == `BEM_IDX_ID);
endmodule : bem_monitor

//--- logic/bem_cfg.svh
// Register indices, field positions and reset values of the monitor
`ifndef BEM_CFG_SVH
`define BEM_CFG_SVH
// Register word indices; byte address is four times the index
`define BEM_IDX_ID 8'h01
`define BEM_IDX_VER 8'h02
`define BEM_IDX_CTRL 8'h08
`define BEM_IDX_WIDTHS 8'h10
`define BEM_IDX_BWIDTHS 8'h11
`define BEM_IDX_CNT0 8'h14
`define BEM_CNT_STRIDE 8'h04
`define BEM_IDX_LAT_MIN 8'h40
`define BEM_IDX_LAT_MAX 8'h44
`define BEM_IDX_CHECK 8'h48
`define BEM_IDX_IRQ_STAT 8'h50
`define BEM_IDX_IRQ_CLR 8'h51
`define BEM_IDX_IRQ_EN 8'h52
// Control word fields
`define BEM_CTRL_STAT_RST 0
`define BEM_CTRL_CHK_RST 8
`define BEM_CTRL_RUN 16
`define BEM_CTRL_ST_LSB 24
// Statistic counters
`define BEM_NUM_CNT 9
`define BEM_CNT_MAX 32'hFFFFFFFF
`define BEM_LAT_MIN_RST 32'hFFFFFFFF
// Arbitrary version value
`define BEM_VERSION 32'h00000001
// Checker flag positions
`define BEM_CHK_W 4
`define BEM_CHK_BOTH 0
`define BEM_CHK_ZBURST 1
`define BEM_CHK_UNSTABLE 2
`define BEM_CHK_STRAY 3
// Interrupt status positions
`define BEM_IRQ_W 3
`define BEM_IRQ_ILLEGAL 0
`define BEM_IRQ_SAT 1
`define BEM_IRQ_OVF 2
`endif

//--- logic/bem_pkg.sv
// Types shared by the bus monitor modules
package bem_pkg;
    // Gathering state
    typedef enum logic [1:0] {BEM_STOPPED, BEM_WAITING, BEM_RUNNING}
        bem_state_t;
endpackage : bem_pkg

//--- logic/bem_fifo_if.sv
// Carrier between monitor core and timestamp queue
interface bem_fifo_if #(parameter int W = 40);
    logic push; // Store wdata
    logic pop; // Drop oldest entry
    logic full; // No room left
    logic empty; // Nothing stored
    logic [W-1:0] wdata; // Entry to store
    logic [W-1:0] rdata; // Oldest entry
    modport fifo (input push, pop, wdata, output full, empty, rdata);
    modport user (output push, pop, wdata, input full, empty, rdata);
endinterface : bem_fifo_if

//--- logic/bem_stamp_fifo.sv
// Timestamp queue for outstanding read commands
module bem_stamp_fifo #(
    parameter int W = 40,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    bem_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH]; // Entry storage
    logic [PW-1:0] wr_ptr_reg; // Next free slot
    logic [PW-1:0] rd_ptr_reg; // Oldest slot
    logic [PW:0] count_reg; // Entries held
    logic do_push; // Accepted push
    logic do_pop; // Accepted pop

    // Pop only when filled, push only when room or popping
    assign do_pop = f.pop && (count_reg != '0);
    assign do_push = f.push && (!f.full || do_pop);
    assign f.full = (count_reg == (PW + 1)'(DEPTH));
    assign f.empty = (count_reg == '0);
    assign f.rdata = mem[rd_ptr_reg];

    // Entry write
    always_ff @(posedge clk_i)
    begin
        if (do_push)
        begin
            mem[wr_ptr_reg] <= f.wdata;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PW + 1)'(do_push)
                         - (PW + 1)'(do_pop);
        end
    end
endmodule : bem_stamp_fifo

//--- tb/bem_ctrl_model.sv
// Controller-side model of the monitored command bus
module bem_ctrl_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] stall_i,
    input wire logic [7:0] lat_i,
    output logic wait_o,
    output logic rdv_o
);
    logic [7:0] cnt_reg; // Stall cycles served so far
    logic [63:0] pend_reg; // Scheduled read beats
    // Hold each command off for stall_i cycles
    assign wait_o = (rd_i | wr_i) ? (cnt_reg < stall_i) : 1'b1;
    assign rdv_o = pend_reg[0];
    // Stall counter, restarts per command
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !(rd_i | wr_i) || !wait_o)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_reg + 8'h01;
    end
    // One beat lat_i cycles after each accepted read
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            pend_reg <= '0;
        else if (rd_i && !wait_o)
            pend_reg <= (pend_reg >> 1) | (64'h1 << (lat_i - 8'h01));
        else
            pend_reg <= pend_reg >> 1;
    end
endmodule : bem_ctrl_model

//--- tb/tb_bus_efficiency_protocol_monitor.sv
// Self-checking bench of the bus monitor
`include "bem_cfg.svh"
module tb_bus_efficiency_protocol_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] ad; logic [31:0] ex;} bem_row_t;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic mrd = 1'b0, mwr = 1'b0, wreq, mwait, rdv, irq;
    logic [7:0] a = 8'h00, stall = 8'h00, lat = 8'h01, bc = 8'h01;
    logic [31:0] wd = 32'h0, q, rdata;
    int num_errors = 0, total_checks = 0;
    bem_row_t rows[9] = '{'{`BEM_IDX_CTRL, 32'h01000000},
        '{`BEM_IDX_VER, `BEM_VERSION}, '{`BEM_IDX_WIDTHS, 32'h00400020},
        '{`BEM_IDX_BWIDTHS, 32'h00080008}, '{`BEM_IDX_LAT_MIN, 32'hFFFFFFFF},
        '{`BEM_IDX_LAT_MAX, 32'h0}, '{`BEM_IDX_CHECK, 32'h0},
        '{`BEM_IDX_IRQ_STAT, 32'h0}, '{8'h7F, 32'h0}};
    bem_monitor dut_u (.CLOCK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(a),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .MON_ADDRESS_I(32'h00000100),
        .MON_READ_I(mrd), .MON_WRITE_I(mwr), .MON_BURSTCOUNT_I(bc),
        .MON_WAITREQUEST_I(mwait), .MON_READDATAVALID_I(rdv), .IRQ_O(irq));
    bem_ctrl_model ctrl_u (.clk_i(clk), .rst_n_i(rst_n), .rd_i(mrd),
        .wr_i(mwr), .stall_i(stall), .lat_i(lat), .wait_o(mwait),
        .rdv_o(rdv));
    // Verdict and end of run
    task automatic test_done();
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Compare and report
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One register cycle, held until waitrequest is sampled low
    task automatic csr(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        a <= ad;
        wd <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0)
        begin
            num_errors++;
            test_done();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : csr
    // Register read with masked compare
    task automatic rc(input string n, input logic [7:0] ad,
        input logic [31:0] e, m);
        csr(1'b0, ad, 32'h0);
        chk(n, e & m, q & m);
    endtask : rc
    // Interrupt line, sampled once settled
    task automatic irq_chk(input logic e);
        @(negedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge clk);
    endtask : irq_chk
    // One monitored command, held through the controller stall
    task automatic mon(input logic r, w, input logic [7:0] b, s, l);
        int n;
        n = 0;
        stall <= s;
        lat <= l;
        mrd <= r;
        mwr <= w;
        bc <= b;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (mwait !== 1'b0 && n < 50);
        if (mwait !== 1'b0)
        begin
            num_errors++;
            test_done();
        end
        mrd <= 1'b0;
        mwr <= 1'b0;
        repeat (l + 2) @(posedge clk);
    endtask : mon
    // Free-running clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i])
            rc("reg", rows[i].ad, rows[i].ex, '1);
        irq_chk(1'b0);
        csr(1'b1, `BEM_IDX_CTRL, 32'h00010101);
        rc("ctrl", `BEM_IDX_CTRL, 32'h02010000, '1);
        mon(1'b0, 1'b1, 8'h01, 8'h01, 8'h01);
        rc("ctrl", `BEM_IDX_CTRL, 32'h04010000, 32'h07010000);
        mon(1'b1, 1'b0, 8'h01, 8'h00, 8'h03);
        mon(1'b1, 1'b0, 8'h01, 8'h02, 8'h07);
        rc("lat min", `BEM_IDX_LAT_MIN, 32'h3, '1);
        rc("lat max", `BEM_IDX_LAT_MAX, 32'h7, '1);
        rc("snap", `BEM_IDX_ID, 32'h0, '1);
        rc("reads", 8'h20, 32'h2, '1);
        rc("beats", 8'h24, 32'h2, '1);
        // Read and write together, then a zero-length burst
        csr(1'b1, `BEM_IDX_IRQ_EN, 32'h1);
        mon(1'b1, 1'b1, 8'h01, 8'h00, 8'h02);
        rc("check", `BEM_IDX_CHECK, 32'h1, 32'h1);
        irq_chk(1'b1);
        csr(1'b1, `BEM_IDX_IRQ_EN, 32'h0);
        irq_chk(1'b0);
        mon(1'b1, 1'b0, 8'h00, 8'h00, 8'h02);
        rc("check", `BEM_IDX_CHECK, 32'h3, 32'h3);
        csr(1'b1, `BEM_IDX_IRQ_EN, 32'h1);
        irq_chk(1'b1);
        csr(1'b1, `BEM_IDX_IRQ_CLR, 32'h1);
        rc("irq stat", `BEM_IDX_IRQ_STAT, 32'h0, 32'h1);
        irq_chk(1'b0);
        // Checker reset: flags cleared, latency minimum restored
        csr(1'b1, `BEM_IDX_CTRL, 32'h00010001);
        rc("check", `BEM_IDX_CHECK, 32'h0, '1);
        rc("lat min", `BEM_IDX_LAT_MIN, 32'hFFFFFFFF, '1);
        // Command dropped while the controller still stalls it
        stall <= 8'h03;
        bc <= 8'h01;
        mrd <= 1'b1;
        @(posedge clk);
        mrd <= 1'b0;
        repeat (2) @(posedge clk);
        rc("check", `BEM_IDX_CHECK, 32'h4, 32'h4);
        csr(1'b1, `BEM_IDX_CTRL, 32'h00010100);
        rc("snap", `BEM_IDX_ID, 32'h0, '1);
        rc("reads", 8'h20, 32'h0, '1);
        // Stopped: no latency update
        csr(1'b1, `BEM_IDX_CTRL, 32'h00000101);
        rc("ctrl", `BEM_IDX_CTRL, 32'h01000000, 32'h07010000);
        mon(1'b1, 1'b0, 8'h01, 8'h00, 8'h02);
        rc("lat min", `BEM_IDX_LAT_MIN, 32'hFFFFFFFF, '1);
        test_done();
    end
endmodule : tb_bus_efficiency_protocol_monitor
